//--- apr_cfg.svh
// Purpose: Constants for the alternate-function pin router.
// Assumes: Included by its bare name from the package and the router.
// Notes:   Offsets, field positions, reset values, masks and structure counts only.
`ifndef APR_CFG_SVH
`define APR_CFG_SVH

// ----------------------------------------------------------------
// Register addresses on the special-function register bus
// ----------------------------------------------------------------
`define APR_ADDR_CTL0 8'hA1
`define APR_ADDR_CTL1 8'hA2
`define APR_ADDR_CTL2 8'hA3

// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define APR_RST_CTL0 8'h00
`define APR_RST_CTL1 8'h00
`define APR_RST_CTL2 8'h00
`define APR_WMASK_CTL0 8'hEF
`define APR_RDATA_NONE 8'h00

// ----------------------------------------------------------------
// clock_pin_and_port4_function_ctrl fields
// ----------------------------------------------------------------
`define APR_CLKSEL_HI 7
`define APR_CLKSEL_LO 6
`define APR_FASTDRV 5
`define APR_PORT4_HI_PAIR_FUNC_SEL_HI 3
`define APR_PORT4_HI_PAIR_FUNC_SEL_LO 2
`define APR_INT1H 1
`define APR_INT0H 0

// ----------------------------------------------------------------
// peripheral_pin_relocation_ctrl fields
// ----------------------------------------------------------------
`define APR_KBI_HI 7
`define APR_KBI_LO 6
`define APR_SPI5 5
`define APR_U1P5 4
`define APR_T2P5 3
`define APR_PCAP6 2
`define APR_EXTRAM 1
`define APR_DPS 0

// ----------------------------------------------------------------
// interrupt_source_select_ctrl fields
// ----------------------------------------------------------------
`define APR_I3_HI 7
`define APR_I3_LO 6
`define APR_I2_HI 5
`define APR_I2_LO 4
`define APR_T1X12 3
`define APR_T0X12 2
`define APR_T1CKOE 1
`define APR_T0CKOE 0

// ----------------------------------------------------------------
// Structure counts
// ----------------------------------------------------------------
`define APR_NPORTS 7
`define APR_DIV_STAGES 3

`endif

//--- apr_pkg.sv
// Purpose: Types shared by the pin router files.
// Assumes: apr_cfg.svh supplies field positions and counts.
// Notes:   Enumerations mirror the two-bit selector encodings.
`include "apr_cfg.svh"

package apr_pkg;

  // ----------------------------------------------------------------
  // Selector encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    APR_CK_GPIO = 2'b00,
    APR_CK_MCK = 2'b01,
    APR_CK_DIV2 = 2'b10,
    APR_CK_DIV4 = 2'b11
  } apr_clksel_t;

  typedef enum logic [1:0] {
    APR_P4_GPIO = 2'b00,
    APR_P4_UART0 = 2'b01,
    APR_P4_EXTIRQ = 2'b10,
    APR_P4_TIMER3 = 2'b11
  } apr_p4func_t;

  typedef enum logic [1:0] {
    APR_KB_P0 = 2'b00,
    APR_KB_P2 = 2'b01,
    APR_KB_P5 = 2'b10,
    APR_KB_P6 = 2'b11
  } apr_kbsel_t;

  typedef enum logic [1:0] {
    APR_IS_OWN = 2'b00,
    APR_IS_UART = 2'b01,
    APR_IS_TWS = 2'b10,
    APR_IS_SPISS = 2'b11
  } apr_irqsrc_t;

  // ----------------------------------------------------------------
  // Router state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctl0;
    logic [7:0] ctl1;
    logic [7:0] ctl2;
    logic [7:0] rdata;
    logic [`APR_NPORTS-1:0][7:0] pdo;
    logic [`APR_NPORTS-1:0][7:0] poe;
    logic [3:0] spi_di;
    logic uart0_rx;
    logic uart1_rx;
    logic t2_clk_in;
    logic t2_ctrl_in;
    logic t3_clk_in;
    logic t3_ctrl_in;
    logic pca_clk_in;
    logic [5:0] pca_di;
    logic [7:0] keypad_irq_input;
    logic irq2;
    logic irq3;
  } apr_state_t;

endpackage

//--- apr_sync.sv
// Purpose: Three-stage pin synchroniser with agreement filter.
// Assumes: Inputs are asynchronous to clk_i.
// Notes:   The filtered value moves only when stages two and three agree.
`timescale 1ns/1ps

module apr_sync #(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } apr_sync_st_t;

  apr_sync_st_t s;
  apr_sync_st_t next_s;

  // ----------------------------------------------------------------
  // Stage shift and per-bit agreement
  // ----------------------------------------------------------------
  // Stage one feeds stage two only, to keep metastability contained
  always_comb begin
    next_s = s;
    if (ce_i) begin
      next_s.s1 = d_i;
      next_s.s2 = s.s1;
      next_s.s3 = s.s2;
      for (int i = 0; i < W; i++) begin
        if (s.s2[i] == s.s3[i]) begin
          next_s.q[i] = s.s3[i];
        end
      end
    end
  end

  // State register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q_o = s.q;

endmodule // apr_sync

//--- apr_clkdiv.sv
// Purpose: Free-running binary divider giving clock-out taps.
// Assumes: Tap i toggles every 2**i enabled cycles.
// Notes:   A flop cannot copy its own clock, so tap 0 is the fastest.
`timescale 1ns/1ps

module apr_clkdiv #(
  parameter int STAGES = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  output logic [STAGES-1:0] tap_o
);

  typedef struct packed {
    logic [STAGES-1:0] cnt;
  } apr_div_st_t;

  apr_div_st_t s;
  apr_div_st_t next_s;

  // Counter advance; each bit is one divided tap
  always_comb begin
    next_s = s;
    if (ce_i) begin
      next_s.cnt = s.cnt + {{(STAGES-1){1'b0}}, 1'b1};
    end
  end

  // State register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tap_o = s.cnt;

endmodule // apr_clkdiv

//--- apr_pin_router.sv
// Purpose: Alternate-function pin router behind three control registers.
// Assumes: SFR bus and peripherals share REF_CLK_I; pins are asynchronous.
// Notes:   Pin and peripheral outputs are registered, one cycle after select.
// Function
// - The clock-pin source field picks GPIO, master clock, half or quarter rate.
// - That field acts only while an internal RC oscillator clocks the system.
// - The fast-drive bit selects default or fast drive for the clock pin.
// - The port-4 pair field maps bits 4 and 5 to GPIO, UART0, ext irqs or Timer 3.
// - The keypad inputs come from port 0, 2, 5 or 6 as the keypad field picks.
// - SPI select, MOSI, MISO and clock move from port 1 bits 4-7 to port 5.
// - UART1 receive and transmit move from port 1 bits 2-3 to port 5.
// - Timer 2 clock and control move from port 1 bits 0-1 to port 5.
// - PCA clock input and six module lines move from port 2 to port 6.
// - External irq 3 comes from its pin, UART1 rx, two-wire data or SPI select.
// - External irq 2 comes from its pin, UART0 rx, two-wire data or SPI select.
`timescale 1ns/1ps
`include "apr_cfg.svh"

module apr_pin_router
  import apr_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic SFR_WE_I,
  input wire logic SFR_RE_I,
  input wire logic [7:0] SFR_WDATA_I,
  output logic [7:0] SFR_RDATA_O,
  input wire logic OSC_IS_RC_I,
  input wire logic [`APR_NPORTS*8-1:0] PIN_I,
  input wire logic [`APR_NPORTS*8-1:0] GPIO_DO_I,
  input wire logic [`APR_NPORTS*8-1:0] GPIO_OE_I,
  output logic [`APR_NPORTS*8-1:0] PIN_DO_O,
  output logic [`APR_NPORTS*8-1:0] PIN_OE_O,
  output logic CLKPIN_FAST_DRIVE_O,
  input wire logic [3:0] SPI_DO_I,
  input wire logic [3:0] SPI_OE_I,
  output logic [3:0] SPI_DI_O,
  input wire logic UART0_TX_I,
  input wire logic UART0_TX_OE_I,
  output logic UART0_RX_O,
  input wire logic UART1_TX_I,
  input wire logic UART1_TX_OE_I,
  output logic UART1_RX_O,
  input wire logic TIMER2_CLK_OUT_I,
  input wire logic TIMER2_CLK_OE_I,
  output logic TIMER2_CLK_IN_O,
  output logic TIMER2_CTRL_IN_O,
  input wire logic TIMER3_CLK_OUT_I,
  input wire logic TIMER3_CLK_OE_I,
  output logic TIMER3_CLK_IN_O,
  output logic TIMER3_CTRL_IN_O,
  input wire logic [5:0] PCA_MODULE_IO_DO_I,
  input wire logic [5:0] PCA_MODULE_IO_OE_I,
  output logic [5:0] PCA_MODULE_IO_DI_O,
  output logic PCA_EXT_CLK_IN_O,
  output logic [7:0] KEYPAD_IRQ_INPUT_O,
  output logic EXT_IRQ2_IN_O,
  output logic EXT_IRQ3_IN_O,
  output logic EXT_IRQ0_HIGH_O,
  output logic EXT_IRQ1_HIGH_O,
  output logic EXT_RAM_SEL_O,
  output logic DPTR_SEL_O,
  output logic TIMER0_X12_O,
  output logic TIMER1_X12_O,
  output logic TIMER0_CLKOUT_EN_O,
  output logic TIMER1_CLKOUT_EN_O
);

  // ----------------------------------------------------------------
  // State, synchronised pins and divider taps
  // ----------------------------------------------------------------
  apr_state_t s;
  apr_state_t next_s;
  logic [`APR_NPORTS*8-1:0] pin_flat;
  logic [`APR_NPORTS-1:0][7:0] pin;
  logic [`APR_NPORTS-1:0][7:0] gdo;
  logic [`APR_NPORTS-1:0][7:0] goe;
  logic [`APR_DIV_STAGES-1:0] tap;

  apr_sync #(.W(`APR_NPORTS*8)) u_sync (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .d_i(PIN_I),
    .q_o(pin_flat)
  );

  apr_clkdiv #(.STAGES(`APR_DIV_STAGES)) u_div (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .tap_o(tap)
  );

  assign pin = pin_flat;
  assign gdo = GPIO_DO_I;
  assign goe = GPIO_OE_I;

  // ----------------------------------------------------------------
  // Field decode, combinational from the registers
  // ----------------------------------------------------------------
  apr_clksel_t clk_sel;
  apr_p4func_t p4_sel;
  apr_kbsel_t kb_sel;
  apr_irqsrc_t i2_sel;
  apr_irqsrc_t i3_sel;
  logic spi_to_port5;
  logic uart1_to_port5;
  logic timer2_to_port5;
  logic pca_to_port6;

  // No handshake: a stored value steers the muxes on the next cycle
  assign clk_sel = apr_clksel_t'(s.ctl0[`APR_CLKSEL_HI:`APR_CLKSEL_LO]);
  assign p4_sel = apr_p4func_t'(s.ctl0[`APR_PORT4_HI_PAIR_FUNC_SEL_HI:`APR_PORT4_HI_PAIR_FUNC_SEL_LO]);
  assign kb_sel = apr_kbsel_t'(s.ctl1[`APR_KBI_HI:`APR_KBI_LO]);
  assign i3_sel = apr_irqsrc_t'(s.ctl2[`APR_I3_HI:`APR_I3_LO]);
  assign i2_sel = apr_irqsrc_t'(s.ctl2[`APR_I2_HI:`APR_I2_LO]);
  // Several set together is the user's fault; each acts on its own pins
  assign spi_to_port5 = s.ctl1[`APR_SPI5];
  assign uart1_to_port5 = s.ctl1[`APR_U1P5];
  assign timer2_to_port5 = s.ctl1[`APR_T2P5];
  assign pca_to_port6 = s.ctl1[`APR_PCAP6];

  // ----------------------------------------------------------------
  // Register file, pin muxes and input routing
  // ----------------------------------------------------------------
  // Everything is held while CE_I is low
  always_comb begin
    logic ss_pin;
    logic own2;
    logic own3;
    ss_pin = 1'b0;
    own2 = 1'b0;
    own3 = 1'b0;
    next_s = s;
    if (CE_I) begin
      // Register writes; the reserved bit of ctl0 stays zero
      if (SFR_WE_I) begin
        case (SFR_ADDR_I)
          `APR_ADDR_CTL0: next_s.ctl0 = SFR_WDATA_I & `APR_WMASK_CTL0;
          `APR_ADDR_CTL1: next_s.ctl1 = SFR_WDATA_I;
          `APR_ADDR_CTL2: next_s.ctl2 = SFR_WDATA_I;
          default: next_s.ctl0 = s.ctl0;
        endcase
      end
      // Reads answer one cycle later; unmapped addresses read zero
      if (SFR_RE_I) begin
        case (SFR_ADDR_I)
          `APR_ADDR_CTL0: next_s.rdata = s.ctl0;
          `APR_ADDR_CTL1: next_s.rdata = s.ctl1;
          `APR_ADDR_CTL2: next_s.rdata = s.ctl2;
          default: next_s.rdata = `APR_RDATA_NONE;
        endcase
      end
      // GPIO everywhere unless a peripheral claims the pin
      next_s.pdo = gdo;
      next_s.poe = goe;
      // Port 0 bit 1: Timer 3 clock out unless moved to port 4
      if (p4_sel != APR_P4_TIMER3 && TIMER3_CLK_OE_I) begin
        next_s.pdo[0][1] = TIMER3_CLK_OUT_I;
        next_s.poe[0][1] = 1'b1;
      end
      // Port 1 or port 5: Timer 2 clock out
      if (TIMER2_CLK_OE_I) begin
        next_s.pdo[timer2_to_port5 ? 5 : 1][0] = TIMER2_CLK_OUT_I;
        next_s.poe[timer2_to_port5 ? 5 : 1][0] = 1'b1;
      end
      // UART1 transmit
      if (UART1_TX_OE_I) begin
        next_s.pdo[uart1_to_port5 ? 5 : 1][3] = UART1_TX_I;
        next_s.poe[uart1_to_port5 ? 5 : 1][3] = 1'b1;
      end
      // SPI lines keep their order, per-line enable
      for (int i = 0; i < 4; i++) begin
        if (SPI_OE_I[i]) begin
          next_s.pdo[spi_to_port5 ? 5 : 1][4+i] = SPI_DO_I[i];
          next_s.poe[spi_to_port5 ? 5 : 1][4+i] = 1'b1;
        end
      end
      // PCA module lines, bits 2 to 7 in order
      for (int i = 0; i < 6; i++) begin
        if (PCA_MODULE_IO_OE_I[i]) begin
          next_s.pdo[pca_to_port6 ? 6 : 2][2+i] = PCA_MODULE_IO_DO_I[i];
          next_s.poe[pca_to_port6 ? 6 : 2][2+i] = 1'b1;
        end
      end
      // UART0 transmit on port 3 bit 1 or port 4 bit 5
      if (UART0_TX_OE_I) begin
        next_s.pdo[p4_sel == APR_P4_UART0 ? 4 : 3][p4_sel == APR_P4_UART0 ? 5 : 1] = UART0_TX_I;
        next_s.poe[p4_sel == APR_P4_UART0 ? 4 : 3][p4_sel == APR_P4_UART0 ? 5 : 1] = 1'b1;
      end
      // Timer 3 clock out on port 4 bit 5
      if (p4_sel == APR_P4_TIMER3 && TIMER3_CLK_OE_I) begin
        next_s.pdo[4][5] = TIMER3_CLK_OUT_I;
        next_s.poe[4][5] = 1'b1;
      end
      // Clock pin: oscillator owns it unless an RC source runs
      if (!OSC_IS_RC_I) begin
        next_s.pdo[6][1:0] = 2'b00;
        next_s.poe[6][1:0] = 2'b00;
      end else begin
        // Drive mode stays with the port mode latch (push-pull advised)
        case (clk_sel)
          APR_CK_GPIO: next_s.pdo[6][0] = gdo[6][0];
          APR_CK_MCK: next_s.pdo[6][0] = tap[0];
          APR_CK_DIV2: next_s.pdo[6][0] = tap[1];
          APR_CK_DIV4: next_s.pdo[6][0] = tap[2];
          default: next_s.pdo[6][0] = gdo[6][0];
        endcase
      end
      // Peripheral inputs from the chosen pins
      next_s.spi_di = spi_to_port5 ? pin[5][7:4] : pin[1][7:4];
      next_s.uart1_rx = uart1_to_port5 ? pin[5][2] : pin[1][2];
      next_s.t2_clk_in = timer2_to_port5 ? pin[5][0] : pin[1][0];
      next_s.t2_ctrl_in = timer2_to_port5 ? pin[5][1] : pin[1][1];
      next_s.pca_clk_in = pca_to_port6 ? pin[6][1] : pin[2][1];
      next_s.pca_di = pca_to_port6 ? pin[6][7:2] : pin[2][7:2];
      next_s.uart0_rx = (p4_sel == APR_P4_UART0) ? pin[4][4] : pin[3][0];
      next_s.t3_ctrl_in = (p4_sel == APR_P4_TIMER3) ? pin[4][4] : pin[0][0];
      next_s.t3_clk_in = (p4_sel == APR_P4_TIMER3) ? pin[4][5] : pin[0][1];
      // Keypad port select
      case (kb_sel)
        APR_KB_P0: next_s.keypad_irq_input = pin[0];
        APR_KB_P2: next_s.keypad_irq_input = pin[2];
        APR_KB_P5: next_s.keypad_irq_input = pin[5];
        APR_KB_P6: next_s.keypad_irq_input = pin[6];
        default: next_s.keypad_irq_input = pin[0];
      endcase
      // Interrupt sources share the routed slave-select pin
      ss_pin = spi_to_port5 ? pin[5][4] : pin[1][4];
      own2 = (p4_sel == APR_P4_EXTIRQ) ? pin[4][4] : pin[4][3];
      own3 = (p4_sel == APR_P4_EXTIRQ) ? pin[4][5] : pin[4][2];
      case (i2_sel)
        APR_IS_OWN: next_s.irq2 = own2;
        APR_IS_UART: next_s.irq2 = (p4_sel == APR_P4_UART0) ? pin[4][4] : pin[3][0];
        APR_IS_TWS: next_s.irq2 = pin[4][1];
        APR_IS_SPISS: next_s.irq2 = ss_pin;
        default: next_s.irq2 = own2;
      endcase
      case (i3_sel)
        APR_IS_OWN: next_s.irq3 = own3;
        APR_IS_UART: next_s.irq3 = uart1_to_port5 ? pin[5][2] : pin[1][2];
        APR_IS_TWS: next_s.irq3 = pin[4][1];
        APR_IS_SPISS: next_s.irq3 = ss_pin;
        default: next_s.irq3 = own3;
      endcase
    end
  end

  // State register
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      s <= '0;
      s.ctl0 <= `APR_RST_CTL0;
      s.ctl1 <= `APR_RST_CTL1;
      s.ctl2 <= `APR_RST_CTL2;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from flops
  // ----------------------------------------------------------------
  assign SFR_RDATA_O = s.rdata;
  assign PIN_DO_O = s.pdo;
  assign PIN_OE_O = s.poe;
  assign CLKPIN_FAST_DRIVE_O = s.ctl0[`APR_FASTDRV];
  assign SPI_DI_O = s.spi_di;
  assign UART0_RX_O = s.uart0_rx;
  assign UART1_RX_O = s.uart1_rx;
  assign TIMER2_CLK_IN_O = s.t2_clk_in;
  assign TIMER2_CTRL_IN_O = s.t2_ctrl_in;
  assign TIMER3_CLK_IN_O = s.t3_clk_in;
  assign TIMER3_CTRL_IN_O = s.t3_ctrl_in;
  assign PCA_MODULE_IO_DI_O = s.pca_di;
  assign PCA_EXT_CLK_IN_O = s.pca_clk_in;
  assign KEYPAD_IRQ_INPUT_O = s.keypad_irq_input;
  assign EXT_IRQ2_IN_O = s.irq2;
  assign EXT_IRQ3_IN_O = s.irq3;
  // Bits kept for neighbouring blocks
  assign EXT_IRQ0_HIGH_O = s.ctl0[`APR_INT0H];
  assign EXT_IRQ1_HIGH_O = s.ctl0[`APR_INT1H];
  assign EXT_RAM_SEL_O = s.ctl1[`APR_EXTRAM];
  assign DPTR_SEL_O = s.ctl1[`APR_DPS];
  assign TIMER0_X12_O = s.ctl2[`APR_T0X12];
  assign TIMER1_X12_O = s.ctl2[`APR_T1X12];
  assign TIMER0_CLKOUT_EN_O = s.ctl2[`APR_T0CKOE];
  assign TIMER1_CLKOUT_EN_O = s.ctl2[`APR_T1CKOE];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);

  sequence s_mck_held;
    (CE_I && OSC_IS_RC_I && clk_sel == APR_CK_MCK) [*2];
  endsequence

  a_write_lands: assert property (CE_I && SFR_WE_I && SFR_ADDR_I == `APR_ADDR_CTL1
      |=> s.ctl1 == $past(SFR_WDATA_I)) else $error("relocation write lost");
  a_clk_fast: assert property (s_mck_held |=> PIN_DO_O[48] != $past(PIN_DO_O[48]))
    else $error("clock pin not toggling");
  a_clk_osc: assert property (CE_I && !OSC_IS_RC_I |=> PIN_OE_O[49:48] == 2'b00)
    else $error("clock pin driven in oscillator mode");
  a_fast_drive: assert property (CE_I && SFR_WE_I && SFR_ADDR_I == `APR_ADDR_CTL0
      |=> CLKPIN_FAST_DRIVE_O == $past(SFR_WDATA_I[`APR_FASTDRV]))
    else $error("fast drive not following");
  a_p4_uart0: assert property (CE_I && p4_sel == APR_P4_UART0
      |=> UART0_RX_O == $past(pin[4][4])) else $error("uart0 rx misrouted");
  a_kbi_port5: assert property (CE_I && kb_sel == APR_KB_P5
      |=> KEYPAD_IRQ_INPUT_O == $past(pin[5])) else $error("keypad port wrong");
  a_spi_moved: assert property (CE_I && spi_to_port5 && SPI_OE_I[1]
      |=> PIN_DO_O[45] == $past(SPI_DO_I[1]) && PIN_OE_O[45])
    else $error("mosi not on port 5");
  a_spi_gpio_back: assert property (CE_I && spi_to_port5
      |=> PIN_OE_O[12] == $past(GPIO_OE_I[12])) else $error("port 1 not freed");
  a_uart1_rx: assert property (CE_I && uart1_to_port5
      |=> UART1_RX_O == $past(pin[5][2])) else $error("uart1 rx misrouted");
  a_timer2_ctrl: assert property (CE_I && !timer2_to_port5
      |=> TIMER2_CTRL_IN_O == $past(pin[1][1])) else $error("timer2 ctrl wrong");
  a_pca_moved: assert property (CE_I && pca_to_port6
      |=> PCA_MODULE_IO_DI_O == $past(pin[6][7:2])) else $error("pca lines wrong");
  a_irq3_tws: assert property (CE_I && i3_sel == APR_IS_TWS
      |=> EXT_IRQ3_IN_O == $past(pin[4][1])) else $error("irq3 source wrong");
  a_irq2_ss: assert property (CE_I && i2_sel == APR_IS_SPISS && !spi_to_port5
      |=> EXT_IRQ2_IN_O == $past(pin[1][4])) else $error("irq2 source wrong");

endmodule // apr_pin_router

//--- apr_periph_model.sv
// Purpose: Peripherals and port pins facing the pin router.
// Assumes: step_i high at an edge draws fresh levels.
// Notes:   Levels hold between steps; misc packs uart/timer data and enables.
`timescale 1ns/1ps

module apr_periph_model (
  input wire logic clk_i,
  input wire logic step_i,
  output logic [55:0] pin_o,
  output logic [3:0] spi_do_o,
  output logic [3:0] spi_oe_o,
  output logic [7:0] misc_o,
  output logic [5:0] pca_do_o,
  output logic [5:0] pca_oe_o
);
  // ----------------------------------------
  // Level source
  // ----------------------------------------
  // Fresh random levels, so a stale route seldom matches by luck
  always @(posedge clk_i) begin
    if (step_i) begin
      pin_o <= 56'({$urandom, $urandom});
      {spi_do_o, spi_oe_o, misc_o} <= 16'($urandom);
      {pca_do_o, pca_oe_o} <= 12'($urandom);
    end
  end

  // Known levels until the first step
  initial begin
    {pin_o, spi_do_o, spi_oe_o, misc_o, pca_do_o, pca_oe_o} = '0;
  end
endmodule // apr_periph_model

//--- apr_pin_router_tb.sv
// Purpose: Self-checking bench for the pin router.
// Assumes: Partner drives pins and peripherals; bench owns SFR bus and GPIO.
// Notes:   Routing is compared once inputs are past the pin synchroniser.
`timescale 1ns/1ps
`include "apr_cfg.svh"

module apr_pin_router_tb;
  logic clk = 0, rst = 1, we = 0, re = 0, rc = 1, step = 0, ce = 1;
  logic [7:0] addr = 0, wd = 0, c0 = 0, c1 = 0, c2 = 0, rdata, misc, kb;
  logic [55:0] gdo = 0, goe = 0, pin, pdo, poe;
  logic [3:0] sdo, soe, sdi;
  logic [5:0] cdo, coe, cdi;
  logic u0rx, u1rx, t2c, t2x, t3c, t3x, pca_ext_clk_in, i2, i3, fd;
  wire [7:0] aux;
  int mismatches = 0, checks_done = 0, n;
  int kp[4] = '{0, 2, 5, 6};

  initial forever #10 clk = ~clk;

  apr_pin_router dut (
    .REF_CLK_I(clk), .RST_I(rst), .CE_I(ce), .SFR_ADDR_I(addr), .SFR_WE_I(we),
    .SFR_RE_I(re), .SFR_WDATA_I(wd), .SFR_RDATA_O(rdata), .OSC_IS_RC_I(rc),
    .PIN_I(pin), .GPIO_DO_I(gdo), .GPIO_OE_I(goe), .PIN_DO_O(pdo), .PIN_OE_O(poe),
    .CLKPIN_FAST_DRIVE_O(fd), .SPI_DO_I(sdo), .SPI_OE_I(soe), .SPI_DI_O(sdi),
    .UART0_TX_I(misc[0]), .UART0_TX_OE_I(misc[1]), .UART0_RX_O(u0rx),
    .UART1_TX_I(misc[2]), .UART1_TX_OE_I(misc[3]), .UART1_RX_O(u1rx),
    .TIMER2_CLK_OUT_I(misc[4]), .TIMER2_CLK_OE_I(misc[5]), .TIMER2_CLK_IN_O(t2c),
    .TIMER2_CTRL_IN_O(t2x), .TIMER3_CLK_OUT_I(misc[6]), .TIMER3_CLK_OE_I(misc[7]),
    .TIMER3_CLK_IN_O(t3c), .TIMER3_CTRL_IN_O(t3x), .PCA_MODULE_IO_DO_I(cdo),
    .PCA_MODULE_IO_OE_I(coe), .PCA_MODULE_IO_DI_O(cdi), .PCA_EXT_CLK_IN_O(pca_ext_clk_in),
    .KEYPAD_IRQ_INPUT_O(kb), .EXT_IRQ2_IN_O(i2), .EXT_IRQ3_IN_O(i3),
    .EXT_IRQ0_HIGH_O(aux[0]), .EXT_IRQ1_HIGH_O(aux[1]), .DPTR_SEL_O(aux[2]),
    .EXT_RAM_SEL_O(aux[3]), .TIMER0_CLKOUT_EN_O(aux[4]), .TIMER1_CLKOUT_EN_O(aux[5]),
    .TIMER0_X12_O(aux[6]), .TIMER1_X12_O(aux[7])
  );

  apr_periph_model peer (
    .clk_i(clk), .step_i(step), .pin_o(pin), .spi_do_o(sdo), .spi_oe_o(soe),
    .misc_o(misc), .pca_do_o(cdo), .pca_oe_o(coe)
  );

  // ----------------------------------------
  // Bus and compare helpers
  // ----------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Inputs move 1 ns after the edge, never on it
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // Strobe drops and an edge passes, so back-to-back calls never clash
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wd = d;
    we = 1;
    tick(1);
    we = 0;
    tick(1);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    addr = a;
    re = 1;
    tick(1);
    re = 0;
    chk(rdata, e);
    tick(1);
  endtask

  task automatic cnt_tog(output int t);
    logic prev;
    t = 0;
    prev = pdo[48];
    repeat (16) begin
      tick(1);
      if (pdo[48] !== prev) t++;
      prev = pdo[48];
    end
  endtask

  // ----------------------------------------
  // Expected routing
  // ----------------------------------------
  function automatic logic pick(input logic [1:0] c, input logic own, input logic u,
                                input logic ss);
    logic [3:0] v;
    v = {ss, pin[33], u, own};
    return v[c];
  endfunction

  function automatic logic [26:0] exp_in();
    logic [3:0] s;
    logic u0, u1, o2, o3;
    s = c1[5] ? pin[47:44] : pin[15:12];
    u0 = (c0[3:2] == 2'h1) ? pin[36] : pin[24];
    u1 = c1[4] ? pin[42] : pin[10];
    o2 = (c0[3:2] == 2'h2) ? pin[36] : pin[35];
    o3 = (c0[3:2] == 2'h2) ? pin[37] : pin[34];
    return {pin[8*kp[c1[7:6]] +: 8], pick(c2[7:6], o3, u1, s[0]), pick(c2[5:4], o2, u0, s[0]),
      c1[2] ? pin[55:49] : pin[23:17], (c0[3:2] == 2'h3) ? pin[37:36] : pin[1:0],
      c1[3] ? pin[41:40] : pin[9:8], u1, u0, s};
  endfunction

  // A peripheral wins its pin only while its enable is high
  function automatic logic [111:0] exp_pin();
    logic [55:0] d, e;
    int ix[14];
    logic [13:0] dv, ov;
    d = gdo;
    e = goe;
    dv = {misc[6], misc[0], cdo, misc[4], misc[2], sdo};
    ov = {misc[7], misc[1], coe, misc[5], misc[3], soe};
    for (int k = 0; k < 4; k++) ix[k] = c1[5] ? 44 + k : 12 + k;
    for (int k = 0; k < 6; k++) ix[6 + k] = c1[2] ? 50 + k : 18 + k;
    ix[4] = c1[4] ? 43 : 11;
    ix[5] = c1[3] ? 40 : 8;
    ix[12] = (c0[3:2] == 2'h1) ? 37 : 25;
    ix[13] = (c0[3:2] == 2'h3) ? 37 : 1;
    for (int k = 0; k < 14; k++) if (ov[k]) {d[ix[k]], e[ix[k]]} = {dv[k], 1'b1};
    if (!rc) {d[49:48], e[49:48]} = 4'h0;
    return {e, d};
  endfunction

  task automatic conclude();
    $display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Run is about 800 cycles; this limit is far beyond it
  initial begin
    #200000;
    mismatches++;
    conclude();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    logic [111:0] x;
    logic [55:0] m;
    logic [26:0] y;
    void'($urandom(34753));
    repeat (3) @(posedge clk);
    #1;
    rst = 0;
    step = 1;
    rdc(`APR_ADDR_CTL0, `APR_RST_CTL0);
    step = 0;
    rdc(`APR_ADDR_CTL1, `APR_RST_CTL1);
    rdc(`APR_ADDR_CTL2, `APR_RST_CTL2);
    wr(8'hA4, 8'hFF);
    rdc(8'hA4, `APR_RDATA_NONE);
    wr(`APR_ADDR_CTL0, 8'hFF);
    rdc(`APR_ADDR_CTL0, `APR_WMASK_CTL0);
    // Clock pin: divider rates with the RC clock, silence without it
    goe[48] = 1'b1;
    for (int k = 1; k < 8; k++) begin
      rc = k[2];
      wr(`APR_ADDR_CTL0, {k[1:0], 6'h00});
      tick(2);
      cnt_tog(n);
      chk(n, (k > 4) ? 16 >> (k - 5) : 0);
    end
    // Enable low: divider, pin outputs and registers all hold
    ce = 0;
    m = pdo;
    wr(`APR_ADDR_CTL0, 8'h00);
    tick(4);
    chk(pdo, m);
    ce = 1;
    rdc(`APR_ADDR_CTL0, 8'hC0);
    // Keypad source moves one edge after the write lands
    wr(`APR_ADDR_CTL1, 8'h40);
    chk(kb, pin[23:16]);
    // Codes cycle by index, other bits random; one relocation bit at most
    for (int i = 0; i < 40; i++) begin
      c0 = {2'($urandom), 1'($urandom), 1'b0, 2'(i / 2), 2'($urandom)};
      c1 = {2'(i / 3), 4'(i % 5 == 0 ? 0 : 8 >> (i % 5 - 1)), 2'($urandom)};
      c2 = {2'(i), 2'(i / 4), 4'($urandom)};
      rc = ($urandom % 4) != 0;
      gdo = 56'({$urandom, $urandom});
      goe = 56'({$urandom, $urandom});
      step = 1;
      wr(`APR_ADDR_CTL0, c0);
      step = 0;
      wr(`APR_ADDR_CTL1, c1);
      wr(`APR_ADDR_CTL2, c2);
      tick(8);
      y = {kb, i3, i2, cdi, pca_ext_clk_in, t3c, t3x, t2x, t2c, u1rx, u0rx, sdi};
      chk(y, exp_in());
      x = exp_pin();
      m = (rc && c0[7:6] != 2'h0) ? 56'h1 << 48 : 56'h0;
      chk(pdo & ~m, x[55:0] & ~m);
      chk(poe, x[111:56]);
      chk(fd, c0[5]);
      chk(aux, {c2[3:0], c1[1:0], c0[1:0]});
      rdc(`APR_ADDR_CTL2, c2);
    end
    conclude();
  end
endmodule // apr_pin_router_tb
